// >>> hdl/timer16_capture_compare.v
// 16-bit timer capture/compare/toggle section with AHB-Lite registers
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "timer16_cc_map.vh"
module timer16_capture_compare #(
  parameter WIDTH = 16
) (
  // clock and reset
  input  wire             mclk_i,
  input  wire             rstn_i,
  // ahb-lite slave
  input  wire             hsel_i,
  input  wire [7:0]       haddr_i,
  input  wire [1:0]       htrans_i,
  input  wire             hwrite_i,
  input  wire [2:0]       hsize_i,
  input  wire             hready_i,
  input  wire [31:0]      hwdata_i,
  output reg  [31:0]      hrdata_o,
  output reg              hreadyout_o,
  output reg              hresp_o,
  // trigger inputs
  input  wire             trigger_in_a_i,
  input  wire             trigger_in_b_i,
  input  wire             companion_timer_toggle_i,
  // events and pin
  output reg              match_a_irq_o,
  output reg              match_b_irq_o,
  output reg              ext_irq_a_o,
  output reg              ext_irq_b_o,
  output reg              timer_out_pin_o,
  output reg              timer_out_pin_oe_o
);

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [8:0]       mode_q;        // timer16_mode_reg
  reg  [5:0]       toggle_q;      // toggle_control_reg
  reg  [1:0]       run_q;         // run_control_reg
  reg  [WIDTH-1:0] compare_a_q;
  reg  [WIDTH-1:0] buffer_a_q;
  reg  [WIDTH-1:0] compare_b_q;
  reg  [WIDTH-1:0] capture_a_q;
  reg  [WIDTH-1:0] capture_b_q;
  reg  [WIDTH-1:0] up_counter_q;
  reg              output_toggle_ff_q;
  reg  [`PRE_WIDTH-1:0] pre_q;
  reg  [`PRE_WIDTH-1:0] pre_d;
  reg              eq_a_q;
  reg              eq_b_q;
  // bus address phase capture
  reg              wr_pend_q;
  reg  [7:0]       addr_q;
  // reset words cut to the width of the registers that they seed
  localparam [31:0] MODE_RST = `MODE_RESET;
  localparam [31:0] TOG_RST  = `TOG_RESET;
  // zero padding of a counter-wide value up to the bus word
  localparam        PADW     = 32 - WIDTH;

  wire [1:0] count_clock_select = mode_q[`MODE_CLK_LSB+1:`MODE_CLK_LSB];
  wire [1:0] capture_mode_field = mode_q[`MODE_CAP_LSB+1:`MODE_CAP_LSB];

  // ---------------------------------------------------------------
  // trigger synchronisers and edge detection
  // ---------------------------------------------------------------
  reg  [2:0] sync_a_q;
  reg  [2:0] sync_b_q;
  reg  [2:0] sync_c_q;
  reg        wave_a_q;

  // two flops then one history flop; only [1] and [2] feed logic
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      sync_a_q <= 3'b000;
      sync_b_q <= 3'b000;
      sync_c_q <= 3'b000;
      wave_a_q <= 1'b0;
    end else begin
      sync_a_q <= {sync_a_q[1:0], trigger_in_a_i};
      sync_b_q <= {sync_b_q[1:0], trigger_in_b_i};
      sync_c_q <= {sync_c_q[1:0], companion_timer_toggle_i};
      // zero-cross input: require agreement of two samples
      if (sync_a_q[2] == sync_a_q[1])
        wave_a_q <= sync_a_q[1];
    end
  end

  // square wave uses the raw synchronised level, sine the filtered one
  wire a_cur  = mode_q[`MODE_WAVE] ? wave_a_q : sync_a_q[1];
  reg  a_prev_q;
  always @(posedge mclk_i) begin
    if (!rstn_i)
      a_prev_q <= 1'b0;
    else
      a_prev_q <= a_cur;
  end
  wire a_rise = a_cur & ~a_prev_q;
  wire a_fall = ~a_cur & a_prev_q;
  wire b_rise = sync_b_q[1] & ~sync_b_q[2];
  wire c_rise = sync_c_q[1] & ~sync_c_q[2];
  wire c_fall = ~sync_c_q[1] & sync_c_q[2];

  // ---------------------------------------------------------------
  // prescaler and count enable
  // ---------------------------------------------------------------
  always @* begin
    pre_d = pre_q + {{(`PRE_WIDTH-1){1'b0}}, 1'b1};
  end

  // prescaler taps give one-cycle enables at /8, /32, /128
  wire tick8   = run_q[`RUN_PRE] && (pre_q[2:0] == 3'b111);
  wire tick32  = run_q[`RUN_PRE] && (pre_q[4:0] == 5'b1_1111);
  wire tick128 = run_q[`RUN_PRE] && (pre_q == {`PRE_WIDTH{1'b1}});
  reg  count_en;
  always @* begin
    case (count_clock_select)
      `CLK_EXT: count_en = a_rise;
      2'b01:    count_en = tick8;
      2'b10:    count_en = tick32;
      2'b11:    count_en = tick128;
      default:  count_en = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // comparators
  // ---------------------------------------------------------------
  // equality flags reset low, so a zero counter against a zero compare
  // register gives one match pulse just after reset
  wire eq_a = (up_counter_q == compare_a_q);
  wire eq_b = (up_counter_q == compare_b_q);
  // a match is an event only on its first cycle of equality
  wire match_a = eq_a & ~eq_a_q;
  wire match_b = eq_b & ~eq_b_q;

  // ---------------------------------------------------------------
  // capture strobes
  // ---------------------------------------------------------------
  reg cap_a_hw;
  reg cap_b_hw;
  always @* begin
    case (capture_mode_field)
      `CAP_OFF: begin
        cap_a_hw = 1'b0;
        cap_b_hw = 1'b0;
      end
      `CAP_AB_RISE: begin
        cap_a_hw = a_rise;
        cap_b_hw = b_rise;
      end
      `CAP_A_PULSE: begin
        cap_a_hw = a_rise;
        cap_b_hw = a_fall;
      end
      `CAP_COMPANION: begin
        cap_a_hw = c_rise;
        cap_b_hw = c_fall;
      end
      default: begin
        cap_a_hw = 1'b0;
        cap_b_hw = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  // hsize is ignored: every register is one whole word
  wire addr_ok = hsel_i && hready_i && htrans_i[1];
  wire wr_now  = wr_pend_q;
  wire wr_mode = wr_now && (addr_q == `OFF_MODE);
  // soft capture fires on each write carrying 0 in that bit
  wire sw_cap  = wr_mode && !hwdata_i[`MODE_SWCAP];
  wire cap_a   = cap_a_hw | sw_cap;
  wire cap_b   = cap_b_hw;

  // ---------------------------------------------------------------
  // counter, prescaler, compare and capture state
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      up_counter_q <= {WIDTH{1'b0}};
      pre_q        <= {`PRE_WIDTH{1'b0}};
      eq_a_q       <= 1'b0;
      eq_b_q       <= 1'b0;
      capture_a_q  <= {WIDTH{1'b0}};
      capture_b_q  <= {WIDTH{1'b0}};
    end else begin
      pre_q  <= run_q[`RUN_PRE] ? pre_d : {`PRE_WIDTH{1'b0}};
      eq_a_q <= eq_a;
      eq_b_q <= eq_b;
      // clear on match b when enabled, hold at zero while the counter is stopped, else wrap freely
      if (run_q[`RUN_CNT] && match_b && mode_q[`MODE_CLE_BIT])
        up_counter_q <= {WIDTH{1'b0}};
      else if (run_q[`RUN_CNT] && count_en)
        up_counter_q <= up_counter_q + {{(WIDTH-1){1'b0}}, 1'b1};
      else if (!run_q[`RUN_CNT])
        up_counter_q <= {WIDTH{1'b0}};
      // capture holds the counter value in the edge cycle
      if (cap_a)
        capture_a_q <= up_counter_q;
      if (cap_b)
        capture_b_q <= up_counter_q;
    end
  end

  // ---------------------------------------------------------------
  // register writes and double buffer
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      mode_q      <= MODE_RST[8:0];
      toggle_q    <= TOG_RST[5:0];
      run_q       <= 2'b00;
      compare_a_q <= {WIDTH{1'b0}};
      buffer_a_q  <= {WIDTH{1'b0}};
      compare_b_q <= {WIDTH{1'b0}};
    end else begin
      if (wr_mode)
        mode_q <= hwdata_i[8:0];
      if (wr_now && addr_q == `OFF_TOGGLE)
        toggle_q <= hwdata_i[5:0];
      if (wr_now && addr_q == `OFF_RUN)
        run_q <= hwdata_i[1:0];
      if (wr_now && addr_q == `OFF_COMPARE_B)
        compare_b_q <= hwdata_i[WIDTH-1:0];
      if (wr_now && addr_q == `OFF_COMPARE_A)
        buffer_a_q <= hwdata_i[WIDTH-1:0];
      // a buffered write in the match-b cycle must not cancel the
      // transfer, so the old buffer moves and the new word waits
      if (wr_now && addr_q == `OFF_COMPARE_A && !mode_q[`MODE_DBUF])
        compare_a_q <= hwdata_i[WIDTH-1:0];
      else if (mode_q[`MODE_DBUF] && match_b)
        compare_a_q <= buffer_a_q;
    end
  end

  // ---------------------------------------------------------------
  // toggle flip-flop
  // ---------------------------------------------------------------
  wire tog_event = (match_a & toggle_q[`TOG_EQA])
                 | (match_b & toggle_q[`TOG_EQB])
                 | (cap_a   & toggle_q[`TOG_CAPA])
                 | (cap_b   & toggle_q[`TOG_CAPB]);
  wire wr_tog    = wr_now && (addr_q == `OFF_TOGGLE);
  wire [1:0] force_code = hwdata_i[`TOG_FORCE_LSB+1:`TOG_FORCE_LSB];

  // a software force overrides a simultaneous hardware toggle
  always @(posedge mclk_i) begin
    if (!rstn_i)
      output_toggle_ff_q <= 1'b0;
    else if (wr_tog && force_code == `FORCE_INV)
      output_toggle_ff_q <= ~output_toggle_ff_q;
    else if (wr_tog && force_code == `FORCE_SET)
      output_toggle_ff_q <= 1'b1;
    else if (wr_tog && force_code == `FORCE_CLR)
      output_toggle_ff_q <= 1'b0;
    else if (tog_event)
      output_toggle_ff_q <= ~output_toggle_ff_q;
  end

  // ---------------------------------------------------------------
  // event outputs and pin
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      match_a_irq_o      <= 1'b0;
      match_b_irq_o      <= 1'b0;
      ext_irq_a_o        <= 1'b0;
      ext_irq_b_o        <= 1'b0;
      timer_out_pin_o    <= 1'b0;
      timer_out_pin_oe_o <= 1'b0;
    end else begin
      match_a_irq_o <= match_a;
      match_b_irq_o <= match_b;
      // external irq a on the fall only in pulse-width capture
      ext_irq_a_o <= (capture_mode_field == `CAP_A_PULSE) ?
                     a_fall : a_rise;
      ext_irq_b_o <= b_rise;
      timer_out_pin_o    <= output_toggle_ff_q;
      timer_out_pin_oe_o <= mode_q[`MODE_OUTEN];
    end
  end

  // ---------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ---------------------------------------------------------------
  always @(posedge mclk_i) begin
    if (!rstn_i) begin
      wr_pend_q   <= 1'b0;
      addr_q      <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_q   <= addr_ok && hwrite_i;
      addr_q      <= haddr_i;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      // read data registered from the address phase
      if (addr_ok && !hwrite_i) begin
        case (haddr_i)
          `OFF_MODE:      hrdata_o <= {23'h00_0000, mode_q};
          `OFF_TOGGLE:    hrdata_o <= {26'h000_0000, toggle_q};
          `OFF_RUN:       hrdata_o <= {30'h0000_0000, run_q};
          `OFF_COMPARE_A: hrdata_o <= {{PADW{1'b0}}, compare_a_q};
          `OFF_COMPARE_B: hrdata_o <= {{PADW{1'b0}}, compare_b_q};
          `OFF_CAPTURE_A: hrdata_o <= {{PADW{1'b0}}, capture_a_q};
          `OFF_CAPTURE_B: hrdata_o <= {{PADW{1'b0}}, capture_b_q};
          `OFF_STATUS:    hrdata_o <= {{(PADW-1){1'b0}},
                                       output_toggle_ff_q, up_counter_q};
          default:        hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule

// >>> hdl/timer16_cc_map.vh
// register map, field positions, reset values for the 16-bit capture/compare timer
`ifndef TIMER16_CC_MAP_VH
`define TIMER16_CC_MAP_VH
// byte offsets of the word registers
`define OFF_MODE      8'h00
`define OFF_TOGGLE    8'h04
`define OFF_RUN       8'h08
`define OFF_COMPARE_A 8'h0C
`define OFF_COMPARE_B 8'h10
`define OFF_CAPTURE_A 8'h14
`define OFF_CAPTURE_B 8'h18
`define OFF_STATUS    8'h1C
// mode register fields
`define MODE_CLK_LSB  0
`define MODE_CAP_LSB  2
`define MODE_CLE_BIT  4
`define MODE_SWCAP    5
`define MODE_DBUF     6
`define MODE_WAVE     7
`define MODE_OUTEN    8
`define MODE_RESET    32'h0000_0020
// toggle control fields
`define TOG_FORCE_LSB 0
`define TOG_EQA       2
`define TOG_EQB       3
`define TOG_CAPA      4
`define TOG_CAPB      5
`define TOG_RESET     32'h0000_0003
// run register fields
`define RUN_CNT       0
`define RUN_PRE       1
// codes
`define CAP_OFF       2'b00
`define CAP_AB_RISE   2'b01
`define CAP_A_PULSE   2'b10
`define CAP_COMPANION 2'b11
`define CLK_EXT       2'b00
`define FORCE_INV     2'b00
`define FORCE_SET     2'b01
`define FORCE_CLR     2'b10
// prescaler taps: 8, 32, 128 system clocks
`define PRE_WIDTH     7
`endif

// >>> sim/timer16_capture_compare_tb.sv
// self-checking bench for the 16-bit capture/compare timer
`timescale 1ns/1ps
`include "timer16_cc_map.vh"
module timer16_capture_compare_tb;
  logic        mclk_i, rstn_i, hsel, hwrite, hready;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  logic        trig_a, trig_b, comp, irq_a, irq_b, ext_a, ext_b, pin, oe;
  int          n_errors, n_checks, na, nb, nea, neb;
  timer16_capture_compare u_timer16_capture_compare (.mclk_i(mclk_i),
    .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'b010), .hready_i(hready),
    .hwdata_i(hwdata), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(), .trigger_in_a_i(trig_a), .trigger_in_b_i(trig_b),
    .companion_timer_toggle_i(comp), .match_a_irq_o(irq_a),
    .match_b_irq_o(irq_b), .ext_irq_a_o(ext_a), .ext_irq_b_o(ext_b),
    .timer_out_pin_o(pin), .timer_out_pin_oe_o(oe));
  timer16_trig_src u_timer16_trig_src (.mclk_i(mclk_i), .trig_a_o(trig_a),
    .trig_b_o(trig_b), .comp_o(comp));
  always #10 mclk_i = ~mclk_i;
  // irqs are single-cycle pulses, so counting high samples counts events
  always @(posedge mclk_i) begin
    if (irq_a === 1'b1) na++;
    if (irq_b === 1'b1) nb++;
    if (ext_a === 1'b1) nea++;
    if (ext_b === 1'b1) neb++;
  end
  // ----------------------------------
  // bus, compare and stimulus helpers
  // ----------------------------------
  // address phase stands until hready is seen; read data taken at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk_i);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge mclk_i); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0000_0000, x);
    chk(x, exp);
  endtask
  task automatic pulse_a(input int n);
    repeat (n) begin
      u_timer16_trig_src.set_line(0, 1'b1);
      u_timer16_trig_src.set_line(0, 1'b0);
    end
  endtask
  // one external event, then freeze the count: stopped prescaler, /8 clock
  task automatic bump(input logic [31:0] mode);
    wr(`OFF_MODE, 32'h0000_0020);
    wr(`OFF_RUN, 32'h0000_0003);
    pulse_a(1);
    wr(`OFF_RUN, 32'h0000_0001);
    wr(`OFF_MODE, mode);
  endtask
  task automatic step(input int sel, input logic v, input logic [31:0] ea,
                      input logic [31:0] eb);
    u_timer16_trig_src.set_line(sel, v);
    rchk(`OFF_CAPTURE_A, ea);
    rchk(`OFF_CAPTURE_B, eb);
  endtask
  // ----------------------------------
  // scenarios
  // ----------------------------------
  task automatic t_reset;
    rchk(`OFF_MODE, `MODE_RESET);
    rchk(`OFF_TOGGLE, `TOG_RESET);
    rchk(`OFF_RUN, 32'h0000_0000);
    chk({30'd0, pin, oe}, 32'h0000_0000);
    wr(8'h20, 32'hffff_ffff);
    rchk(8'h20, 32'h0000_0000);
    $display("test reset done");
  endtask
  task automatic t_event;
    wr(`OFF_RUN, 32'h0000_0003);
    pulse_a(5);
    rchk(`OFF_CAPTURE_A, 32'h0000_0000);
    wr(`OFF_MODE, 32'h0000_0000);
    rchk(`OFF_CAPTURE_A, 32'h0000_0005);
    rchk(`OFF_STATUS, 32'h0000_0005);
    $display("test event count done");
  endtask
  task automatic t_capture;
    int e;
    bump(32'h0000_0025);
    e = neb;
    step(1, 1'b1, 32'h5, 32'h6);
    chk(neb - e, 1);
    step(1, 1'b0, 32'h5, 32'h6);
    e = nea;
    step(0, 1'b1, 32'h6, 32'h6);
    chk(nea - e, 1);
    step(0, 1'b0, 32'h6, 32'h6);
    bump(32'h0000_0029);
    e = nea;
    step(0, 1'b1, 32'h7, 32'h6);
    chk(nea - e, 0);
    step(0, 1'b0, 32'h7, 32'h7);
    chk(nea - e, 1);
    bump(32'h0000_002d);
    step(2, 1'b1, 32'h8, 32'h7);
    step(2, 1'b0, 32'h8, 32'h8);
    $display("test capture modes done");
  endtask
  task automatic t_match;
    int a0, b0;
    wr(`OFF_MODE, 32'h0000_0130);
    wr(`OFF_RUN, 32'h0000_0002);
    wr(`OFF_COMPARE_A, 32'h0000_0002);
    wr(`OFF_COMPARE_B, 32'h0000_0004);
    wr(`OFF_TOGGLE, 32'h0000_000e);
    wr(`OFF_RUN, 32'h0000_0003);
    a0 = na;
    b0 = nb;
    pulse_a(2);
    rchk(`OFF_STATUS, 32'h0001_0002);
    chk({31'd0, pin & oe}, 32'h1);
    pulse_a(2);
    rchk(`OFF_STATUS, 32'h0000_0000);
    chk(na - a0, 1);
    chk(nb - b0, 1);
    wr(`OFF_MODE, 32'h0000_0120);
    pulse_a(5);
    rchk(`OFF_STATUS, 32'h0000_0005);
    chk(nb - b0, 2);
    $display("test compare and clear done");
  endtask
  task automatic t_force;
    logic [1:0] code [4] = '{2'b01, 2'b10, 2'b00, 2'b11};
    logic       ff   [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr(`OFF_TOGGLE, {30'd0, code[i]});
      rchk(`OFF_STATUS, {15'd0, ff[i], 16'h0005});
    end
    $display("test force codes done");
  endtask
  // buffered compare a, then zero-cross input with capture toggles
  task automatic t_dbuf_wave;
    int e;
    wr(`OFF_MODE, 32'h0000_0160);
    wr(`OFF_RUN, 32'h0000_0002);
    wr(`OFF_COMPARE_A, 32'h0000_0007);
    rchk(`OFF_COMPARE_A, 32'h0000_0002);
    wr(`OFF_RUN, 32'h0000_0003);
    pulse_a(4);
    rchk(`OFF_COMPARE_A, 32'h0000_0007);
    wr(`OFF_MODE, 32'h0000_01a8);
    wr(`OFF_TOGGLE, 32'h0000_0033);
    e = nea;
    u_timer16_trig_src.spike_a;
    rchk(`OFF_STATUS, 32'h0001_0004);
    step(0, 1'b1, 32'h4, 32'h8);
    rchk(`OFF_STATUS, 32'h0000_0005);
    step(0, 1'b0, 32'h4, 32'h5);
    rchk(`OFF_STATUS, 32'h0001_0005);
    chk(nea - e, 1);
    $display("test buffer and filter done");
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // run is under five hundred cycles; the limit leaves ample margin
  initial begin
    repeat (20000) @(posedge mclk_i);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    wrap_up;
  end
  initial begin
    mclk_i = 1'b0;
    rstn_i = 1'b0;
    hsel   = 1'b0;
    hwrite = 1'b0;
    haddr  = 8'h00;
    htrans = 2'b00;
    hwdata = 32'h0000_0000;
    repeat (4) @(posedge mclk_i);
    rstn_i <= 1'b1;
    t_reset;
    t_event;
    t_capture;
    t_match;
    t_force;
    t_dbuf_wave;
    wrap_up;
  end
endmodule

// >>> sim/timer16_cc_props.sv
// port checker for the 16-bit capture/compare timer
`timescale 1ns/1ps
module timer16_cc_chk (
  // clock and bus
  input logic        mclk_i,
  input logic        rstn_i,
  input logic        hsel_i,
  input logic [7:0]  haddr_i,
  input logic [1:0]  htrans_i,
  input logic        hwrite_i,
  input logic        hready_i,
  input logic [31:0] hrdata_o,
  input logic        hreadyout_o,
  input logic        hresp_o,
  // triggers, events and pin
  input logic        trigger_in_a_i,
  input logic        trigger_in_b_i,
  input logic        companion_timer_toggle_i,
  input logic        match_a_irq_o,
  input logic        match_b_irq_o,
  input logic        ext_irq_a_o,
  input logic        ext_irq_b_o,
  input logic        timer_out_pin_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  // ---------------------------------------------
  // ages since a cause; they saturate, never wrap
  // ---------------------------------------------
  logic       a_q, b_q, c_q, wr_q, cause;
  logic [3:0] a_age_q, ev_age_q;
  // trigger moves count as causes: a capture latch may toggle the pin
  assign cause = wr_q | match_a_irq_o | match_b_irq_o | ext_irq_a_o |
                 ext_irq_b_o | (c_q != companion_timer_toggle_i) |
                 (a_q != trigger_in_a_i) | (b_q != trigger_in_b_i);
  always_ff @(posedge mclk_i) begin
    a_q  <= trigger_in_a_i;
    b_q  <= trigger_in_b_i;
    c_q  <= companion_timer_toggle_i;
    wr_q <= rstn_i & hsel_i & hready_i & htrans_i[1] & hwrite_i;
    if (!rstn_i)
      a_age_q <= 4'hf;
    else if (a_q != trigger_in_a_i)
      a_age_q <= 4'h0;
    else if (a_age_q != 4'hf)
      a_age_q <= a_age_q + 4'h1;
    if (!rstn_i)
      ev_age_q <= 4'hf;
    else if (cause)
      ev_age_q <= 4'h0;
    else if (ev_age_q != 4'hf)
      ev_age_q <= ev_age_q + 4'h1;
  end
  AST_BUS_READY: assert property (hreadyout_o)
    else $error("slave stalled the bus");
  AST_BUS_OKAY: assert property (!hresp_o)
    else $error("error response on the bus");
  AST_UNMAPPED_READ: assert property (hsel_i && hready_i && htrans_i[1] &&
    !hwrite_i && haddr_i >= 8'h20 |=> hrdata_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  AST_MATCH_A_PULSE: assert property (match_a_irq_o |=> !match_a_irq_o)
    else $error("match a irq longer than one cycle");
  AST_MATCH_B_PULSE: assert property (match_b_irq_o |=> !match_b_irq_o)
    else $error("match b irq longer than one cycle");
  AST_EXT_A_CAUSE: assert property (ext_irq_a_o |-> a_age_q <= 4'd6)
    else $error("ext irq a without a trigger edge");
  AST_EXT_B_DELAY: assert property ($rose(trigger_in_b_i) |-> ##[2:6] ext_irq_b_o)
    else $error("ext irq b missing after rise");
  AST_PIN_CAUSE: assert property ($changed(timer_out_pin_o) |-> ev_age_q <= 4'd7)
    else $error("timer pin moved without an event");
  cover property (match_b_irq_o);
  cover property (ext_irq_a_o);
  cover property ($rose(timer_out_pin_o));
endmodule
bind timer16_capture_compare timer16_cc_chk u_timer16_cc_chk (.mclk_i,
  .rstn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
  .hreadyout_o, .hresp_o, .trigger_in_a_i, .trigger_in_b_i,
  .companion_timer_toggle_i, .match_a_irq_o, .match_b_irq_o, .ext_irq_a_o,
  .ext_irq_b_o, .timer_out_pin_o);

// >>> sim/timer16_trig_src.sv
// trigger source model: external trigger pins and companion toggle level
`timescale 1ns/1ps
module timer16_trig_src (
  // clock used to place edges
  input  logic mclk_i,
  // lines toward the timer
  output logic trig_a_o,
  output logic trig_b_o,
  output logic comp_o
);
  initial begin
    trig_a_o = 1'b0;
    trig_b_o = 1'b0;
    comp_o   = 1'b0;
  end
  // clean square edges, held 4 clocks so the synchroniser never misses one
  task automatic set_line(input int sel, input logic v);
    @(posedge mclk_i);
    case (sel)
      0: trig_a_o <= v;
      1: trig_b_o <= v;
      default: comp_o <= v;
    endcase
    repeat (4) @(posedge mclk_i);
  endtask
  // one-clock spike on trigger a, which the zero-cross filter must drop
  task automatic spike_a;
    @(posedge mclk_i);
    trig_a_o <= 1'b1;
    @(posedge mclk_i);
    trig_a_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
  endtask
endmodule
